// >>> include/ies_defs.svh
// Register offsets, field positions and reset values of the internal error severity block.
// Included by the package and by the design files; definitions only.
`ifndef IES_DEFS_SVH
`define IES_DEFS_SVH

`define IES_ADDR_W 12
`define IES_ERR_W 14
`define IES_OFF_MASK 12'h488
`define IES_OFF_SEV 12'h48C
`define IES_OFF_TEST 12'h490
`define IES_OFF_STATUS 12'h484
`define IES_OFF_IRQ_STAT 12'h4A0
`define IES_OFF_IRQ_MASK 12'h4A4
`define IES_RSVD_BIT 3
`define IES_SEV_RST 14'h1511
`define IES_SEV_IMPL 14'h3FF7
`define IES_MASK_RST 14'h0000
`define IES_IRQ_W 2
`define IES_IRQ_UNCOR 0
`define IES_IRQ_COR 1
`define IES_RESP_OKAY 2'h0
`define IES_RESP_SLVERR 2'h2

`endif

// >>> include/ies_pkg.sv
// Types shared by the internal error severity block.
// Assumes ies_defs.svh is on the include path.
`include "ies_defs.svh"
package ies_pkg;
	typedef logic [`IES_ERR_W-1:0] ies_err_vec_t;
	typedef struct packed {
		logic uncor;
		logic cor;
	} ies_report_t;
	typedef enum logic [1:0] {
		IES_WR_IDLE = 2'b00,
		IES_WR_RESP = 2'b01
	} ies_wr_state_t;
endpackage

// >>> core/ies_classify.sv
// Classifies pending, unmasked internal errors as uncorrectable or correctable.
// Assumes all inputs are registered in the same clock domain.
`timescale 1ns/100ps
`include "ies_defs.svh"
module ies_classify #(
	parameter int ERR_W = `IES_ERR_W
) (
	input wire logic [ERR_W-1:0] status_i,
	input wire logic [ERR_W-1:0] mask_i,
	input wire logic [ERR_W-1:0] sev_i,
	output logic [ERR_W-1:0] uncor_o,
	output logic [ERR_W-1:0] cor_o
);
	genvar g;
	generate
		for (g = 0; g < ERR_W; g++) begin : g_bit
			// Severity only steers a bit that is already pending and unmasked
			wire live = status_i[g] & ~mask_i[g]; // [R03] [R09]
			assign uncor_o[g] = live & sev_i[g]; // [R01]
			assign cor_o[g] = live & ~sev_i[g]; // [R02]
		end
	endgenerate
endmodule // ies_classify

// >>> core/ies_top.sv
// Operation
// [R01] Severity one reports error as uncorrectable
// [R02] Severity zero reports error as correctable
// [R03] Severity only classifies pending unmasked errors
// [R04] Bits 0-2 ingress timeouts; bit0 resets one
// [R05] Bits 4-6 egress timeouts; bit4 resets one
// [R06] Bits 7-10 ingress ECC; double-bit reset one
// [R07] Bits 11-13 egress ECC; bit12 resets one
// [R08] Bit 3 reads zero; others read/write
// [R09] Mask blocks reporting, status stays unchanged
// [R10] Test write sets status; reads zero
//
// Internal error severity register bank with status, mask, test, AXI4-Lite slave.
// Assumes error event inputs are one-cycle pulses synchronous to REF_CLK_I.
`timescale 1ns/100ps
`include "ies_defs.svh"
module ies_top #(
	parameter int ERR_W = `IES_ERR_W
) (
	input wire logic REF_CLK_I,
	input wire logic SRST_I,
	input wire logic [ERR_W-1:0] ERR_EVENT_I,
	output logic UNCOR_ERR_O,
	output logic COR_ERR_O,
	output logic [ERR_W-1:0] UNCOR_VEC_O,
	output logic [ERR_W-1:0] COR_VEC_O,
	output logic IRQ_O,
	input wire logic [`IES_ADDR_W-1:0] AWADDR_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	output logic [1:0] BRESP_O,
	output logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic [`IES_ADDR_W-1:0] ARADDR_I,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	output logic [31:0] RDATA_O,
	output logic [1:0] RRESP_O,
	output logic RVALID_O,
	input wire logic RREADY_I
);
	logic [ERR_W-1:0] sev_r, mask_r, status_r;
	logic [ERR_W-1:0] sev_nxt, mask_nxt, status_nxt;
	logic [`IES_IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_stat_nxt, irq_mask_nxt;
	logic [`IES_ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic aw_held_r, w_held_r;
	ies_pkg::ies_wr_state_t wr_state_r;
	logic [ERR_W-1:0] uncor_vec, cor_vec;
	ies_pkg::ies_report_t report, report_r;

	ies_classify #(.ERR_W(ERR_W)) u_classify (
		.status_i(status_r),
		.mask_i(mask_r),
		.sev_i(sev_r),
		.uncor_o(uncor_vec),
		.cor_o(cor_vec)
	);
	assign report.uncor = |uncor_vec; // [R01]
	assign report.cor = |cor_vec; // [R02]

	// Write channel: address and data are latched independently, in either order
	wire aw_take = AWVALID_I & ~aw_held_r & (wr_state_r == ies_pkg::IES_WR_IDLE);
	wire w_take = WVALID_I & ~w_held_r & (wr_state_r == ies_pkg::IES_WR_IDLE);
	wire aw_have = aw_held_r | aw_take;
	wire w_have = w_held_r | w_take;
	wire wr_fire = aw_have & w_have & (wr_state_r == ies_pkg::IES_WR_IDLE);
	wire [`IES_ADDR_W-1:0] wr_addr = aw_held_r ? awaddr_r : AWADDR_I;
	wire [31:0] wr_data = w_held_r ? wdata_r : WDATA_I;
	wire [3:0] wr_strb = w_held_r ? wstrb_r : WSTRB_I;
	wire [31:0] wr_bmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
	wire [ERR_W-1:0] wr_bits = wr_data[ERR_W-1:0] & wr_bmask[ERR_W-1:0];
	wire [ERR_W-1:0] wr_keep = ~wr_bmask[ERR_W-1:0];
	wire [`IES_ADDR_W-1:0] wr_word = {wr_addr[`IES_ADDR_W-1:2], 2'b00};
	wire wr_sev = wr_fire & (wr_word == `IES_OFF_SEV);
	wire wr_mask = wr_fire & (wr_word == `IES_OFF_MASK);
	wire wr_test = wr_fire & (wr_word == `IES_OFF_TEST);
	wire wr_status = wr_fire & (wr_word == `IES_OFF_STATUS);
	wire wr_irq_mask = wr_fire & (wr_word == `IES_OFF_IRQ_MASK);
	wire wr_ok = wr_sev | wr_mask | wr_test | wr_status | wr_irq_mask | (wr_word == `IES_OFF_IRQ_STAT);

	// Read channel: one-deep, answered the cycle after the address is taken
	wire ar_take = ARVALID_I & ~RVALID_O;
	wire [`IES_ADDR_W-1:0] rd_word = {ARADDR_I[`IES_ADDR_W-1:2], 2'b00};
	wire rd_sev = rd_word == `IES_OFF_SEV;
	wire rd_mask = rd_word == `IES_OFF_MASK;
	wire rd_test = rd_word == `IES_OFF_TEST;
	wire rd_status = rd_word == `IES_OFF_STATUS;
	wire rd_irq_stat = rd_word == `IES_OFF_IRQ_STAT;
	wire rd_irq_mask = rd_word == `IES_OFF_IRQ_MASK;
	wire rd_ok = rd_sev | rd_mask | rd_test | rd_status | rd_irq_stat | rd_irq_mask;
	wire [ERR_W-1:0] rd_bits = rd_sev ? sev_r :
		rd_mask ? mask_r :
		rd_status ? status_r : '0; // [R10]
	wire [31:0] rd_data = rd_irq_stat ? {30'h0, irq_stat_r} :
		rd_irq_mask ? {30'h0, irq_mask_r} : {{(32-ERR_W){1'b0}}, rd_bits};

	// Reserved bit forced low on write so it always reads zero
	assign sev_nxt = wr_sev ? (((sev_r & wr_keep) | wr_bits) & `IES_SEV_IMPL) : sev_r; // [R08]
	assign mask_nxt = wr_mask ? (((mask_r & wr_keep) | wr_bits) & `IES_SEV_IMPL) : mask_r; // [R09]
	// Status is write-one-to-clear; a new event or test write in the same cycle wins
	wire [ERR_W-1:0] st_clr = wr_status ? wr_bits : '0;
	wire [ERR_W-1:0] st_set = (ERR_EVENT_I | (wr_test ? wr_bits : '0)) & `IES_SEV_IMPL; // [R10]
	assign status_nxt = (status_r & ~st_clr) | st_set;
	wire [`IES_IRQ_W-1:0] irq_evt = {report.cor & ~report_r.cor, report.uncor & ~report_r.uncor};
	wire irq_rd_clr = ar_take & rd_irq_stat;
	assign irq_stat_nxt = (irq_rd_clr ? '0 : irq_stat_r) | irq_evt;
	assign irq_mask_nxt = wr_irq_mask ? (wr_bits[`IES_IRQ_W-1:0] | (irq_mask_r & wr_keep[`IES_IRQ_W-1:0])) : irq_mask_r;

	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			sev_r <= `IES_SEV_RST; // [R04] [R05] [R06] [R07]
			mask_r <= `IES_MASK_RST;
			status_r <= '0;
			irq_stat_r <= '0;
			irq_mask_r <= '0;
			report_r <= '0;
		end else begin
			sev_r <= sev_nxt;
			mask_r <= mask_nxt;
			status_r <= status_nxt;
			irq_stat_r <= irq_stat_nxt;
			irq_mask_r <= irq_mask_nxt;
			report_r <= report;
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			UNCOR_ERR_O <= 1'b0;
			COR_ERR_O <= 1'b0;
			UNCOR_VEC_O <= '0;
			COR_VEC_O <= '0;
			IRQ_O <= 1'b0;
		end else begin
			UNCOR_ERR_O <= report.uncor; // [R01]
			COR_ERR_O <= report.cor; // [R02]
			UNCOR_VEC_O <= uncor_vec; // [R03]
			COR_VEC_O <= cor_vec; // [R03]
			IRQ_O <= |(irq_stat_nxt & irq_mask_nxt);
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else begin
			aw_held_r <= aw_have & ~wr_fire;
			w_held_r <= w_have & ~wr_fire;
			if (aw_take) begin
				awaddr_r <= AWADDR_I;
			end
			if (w_take) begin
				wdata_r <= WDATA_I;
				wstrb_r <= WSTRB_I;
			end
		end
	end

	// Ready is a registered pulse; this costs a cycle per channel but keeps outputs flopped
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			AWREADY_O <= 1'b0;
			WREADY_O <= 1'b0;
			BVALID_O <= 1'b0;
			BRESP_O <= `IES_RESP_OKAY;
			wr_state_r <= ies_pkg::IES_WR_IDLE;
		end else begin
			AWREADY_O <= 1'b0;
			WREADY_O <= 1'b0;
			unique case (wr_state_r)
				ies_pkg::IES_WR_IDLE: begin
					if (wr_fire) begin
						AWREADY_O <= 1'b1;
						WREADY_O <= 1'b1;
						BVALID_O <= 1'b1;
						BRESP_O <= wr_ok ? `IES_RESP_OKAY : `IES_RESP_SLVERR;
						wr_state_r <= ies_pkg::IES_WR_RESP;
					end
				end
				ies_pkg::IES_WR_RESP: begin
					if (BREADY_I) begin
						BVALID_O <= 1'b0;
						wr_state_r <= ies_pkg::IES_WR_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			ARREADY_O <= 1'b0;
			RVALID_O <= 1'b0;
			RDATA_O <= '0;
			RRESP_O <= `IES_RESP_OKAY;
		end else begin
			ARREADY_O <= 1'b0;
			if (ar_take & ~ARREADY_O) begin
				ARREADY_O <= 1'b1;
				RVALID_O <= 1'b1;
				RDATA_O <= rd_ok ? rd_data : 32'h0;
				RRESP_O <= rd_ok ? `IES_RESP_OKAY : `IES_RESP_SLVERR;
			end else if (RVALID_O & RREADY_I) begin
				RVALID_O <= 1'b0;
			end
		end
	end
endmodule // ies_top

// >>> dv/ies_chk.sv
// Port checker of the internal error severity block.
// Assumes it is bound to ies_top and sees only its ports.
`timescale 1ns/100ps
module ies_chk #(
	parameter int ERR_W = 14
) (
	input wire logic REF_CLK_I,
	input wire logic SRST_I,
	input wire logic UNCOR_ERR_O,
	input wire logic COR_ERR_O,
	input wire logic [ERR_W-1:0] UNCOR_VEC_O,
	input wire logic [ERR_W-1:0] COR_VEC_O,
	input wire logic AWVALID_I,
	input wire logic WVALID_I,
	input wire logic AWREADY_O,
	input wire logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic ARVALID_I,
	input wire logic ARREADY_O,
	input wire logic [31:0] RDATA_O,
	input wire logic RVALID_O,
	input wire logic RREADY_I
);
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (SRST_I);
	property p_uncor_any; UNCOR_ERR_O == (|UNCOR_VEC_O); endproperty
	a_uncor_any: assert property (p_uncor_any) else $error("uncorrectable flag off");
	property p_cor_any; COR_ERR_O == (|COR_VEC_O); endproperty
	a_cor_any: assert property (p_cor_any) else $error("correctable flag off");
	property p_one_class; (UNCOR_VEC_O & COR_VEC_O) == '0; endproperty
	a_one_class: assert property (p_one_class) else $error("error in both classes");
	property p_rsvd; !UNCOR_VEC_O[3] && !COR_VEC_O[3]; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved type reported");
	property p_wr_ans; AWVALID_I && WVALID_I && !BVALID_O && !AWREADY_O |=> AWREADY_O && BVALID_O; endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
	property p_b_hold; BVALID_O && !BREADY_I |=> BVALID_O; endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_rd_ans; ARVALID_I && !RVALID_O && !ARREADY_O |=> ARREADY_O && RVALID_O; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_r_hold; RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule // ies_chk
bind ies_top ies_chk #(.ERR_W(ERR_W)) i_chk (.REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I), .UNCOR_ERR_O(UNCOR_ERR_O),
	.COR_ERR_O(COR_ERR_O), .UNCOR_VEC_O(UNCOR_VEC_O), .COR_VEC_O(COR_VEC_O), .AWVALID_I(AWVALID_I),
	.WVALID_I(WVALID_I), .AWREADY_O(AWREADY_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
	.ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I));

// >>> dv/ies_aer_model.sv
// Error reporting partner: counts new reports of each class.
// Assumes level reports in the block clock domain.
`timescale 1ns/100ps
module ies_aer_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic uncor_i,
	input wire logic cor_i,
	output logic [7:0] n_uncor_o,
	output logic [7:0] n_cor_o
);
	logic uncor_r;
	logic cor_r;
	// One message per rising edge, as a level held high is one pending report
	always_ff @(posedge clk_i) begin
		uncor_r <= uncor_i;
		cor_r <= cor_i;
		n_uncor_o <= rst_i ? 8'h00 : n_uncor_o + {7'h00, uncor_i & ~uncor_r};
		n_cor_o <= rst_i ? 8'h00 : n_cor_o + {7'h00, cor_i & ~cor_r};
	end
endmodule // ies_aer_model

// >>> dv/internal_error_severity_test.sv
// Testbench of the internal error severity block over AXI4-Lite.
// Assumes the design and its checker are compiled before it.
`timescale 1ns/100ps
module internal_error_severity_test;
	logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic [11:0] awa = 12'h000, ara = 12'h000;
	logic [31:0] wd = 32'h0, d, rdata;
	logic [13:0] ev = 14'h0000, uv, cv;
	logic [1:0] resp, bresp, rresp;
	logic ue, ce, irq, awr, wrr, bv, arr, rv;
	logic [7:0] nu, nc;
	int fail_count = 0, n_tests = 0;
	always #2 clk = ~clk;
	ies_top i_dut (.REF_CLK_I(clk), .SRST_I(rst), .ERR_EVENT_I(ev), .UNCOR_ERR_O(ue), .COR_ERR_O(ce),
		.UNCOR_VEC_O(uv), .COR_VEC_O(cv), .IRQ_O(irq), .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awr),
		.WDATA_I(wd), .WSTRB_I(4'hF), .WVALID_I(wv), .WREADY_O(wrr), .BRESP_O(bresp), .BVALID_O(bv),
		.BREADY_I(bry), .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rdata), .RRESP_O(rresp),
		.RVALID_O(rv), .RREADY_I(rry));
	ies_aer_model i_aer (.clk_i(clk), .rst_i(rst), .uncor_i(ue), .cor_i(ce), .n_uncor_o(nu), .n_cor_o(nc));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected at %0t: seen 0x%h expected 0x%h", $time, s, e);
		end
	endtask
	// Ready is raised only once the address is taken, so the slave also sees a stalled master
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) begin awv <= 1'b0; bry <= 1'b1; end
			if (wrr) wv <= 1'b0;
		end while (!(bv === 1'b1 && bry === 1'b1));
		resp = bresp;
		bry <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] a);
		ara <= a; arv <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) begin arv <= 1'b0; rry <= 1'b1; end
		end while (!(rv === 1'b1 && rry === 1'b1));
		d = rdata; resp = rresp;
		rry <= 1'b0;
		@(posedge clk);
	endtask
	task automatic conclude();
		if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic settle(); repeat (4) @(posedge clk); endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(12'h48C); chk(d, 32'h00001511);
		wr(12'h48C, 32'hFFFFFFFF); rd(12'h48C); chk(d, 32'h00003FF7);
		wr(12'h48C, 32'h00000001); wr(12'h4A4, 32'h0);
		ev <= 14'h0003; @(posedge clk); ev <= 14'h0000; settle();
		chk({uv, cv}, {14'h0001, 14'h0002});
		chk({nu, nc, 15'h0000, irq}, 32'h01010000);
		wr(12'h48C, 32'h00000022); settle();
		chk({uv, cv}, {14'h0002, 14'h0001});
		wr(12'h488, 32'h00000001); rd(12'h488); chk(d, 32'h00000001); settle();
		chk({uv, cv}, {14'h0002, 14'h0000});
		rd(12'h484); chk(d, 32'h00000003);
		wr(12'h484, 32'h00000003); wr(12'h490, 32'h00000010); rd(12'h490); chk(d, 32'h0);
		rd(12'h484); chk(d, 32'h00000010); settle();
		chk({uv, cv}, {14'h0000, 14'h0010});
		wr(12'h4A4, 32'h00000003); settle(); chk(irq, 1'b1);
		rd(12'h4A0); settle(); chk(irq, 1'b0);
		rd(12'h100); chk(d, 32'h0); chk(resp, 2'h2);
		wr(12'h100, 32'h1); chk(resp, 2'h2);
		conclude();
	end
	initial begin
		#20000;
		fail_count++;
		conclude();
	end
endmodule // internal_error_severity_test
